// >>> rtc_irq_event_enable_clear.sv
// holds the interrupt enable, flag and event-output enable logic of a
// real-time counter, reached over a plain strobe register port.
// assumes all inputs are synchronous to clock and source events are
// one-cycle pulses from the counter datapath.
//
// Function
// R1 - alarm-zero event is emitted on each alarm only while its enable is one
// R2 - eight periodic events, each produced only while its own enable is one
// R3 - zero bits written to the enable-clear register change nothing
// R4 - writing one to bit 7 clears the overflow interrupt enable
// R5 - writing one to bit 6 clears the sync-ready interrupt enable
// R6 - in counter32 mode bit 0 clears the compare-zero interrupt enable
// R7 - in counter16 mode bits 1 and 0 clear channel one and zero enables
// R8 - interrupt request raised when enable and flag both set, never else
// R9 - reading enable-clear returns current enable states
// R10 - in calendar mode bit 0 clears the alarm-zero interrupt enable
// R11 - enable-set register at 0x07 sets the same enables by ones
// R12 - flag register at 0x08; ones clear flags, zeros leave them
// R13 - enable writes ignored under write protection; enables reset to zero
// R14 - unused enable bits read zero and ignore writes
module rtc_irq_event_enable_clear (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic                     write_protect,
  input  wire rtc_irq_pkg::bus_req_t    bus_req,
  input  wire rtc_irq_pkg::src_events_t src_events,
  output logic [7:0]                    rd_data,
  output logic                          irq_req,
  output logic                          alarm_zero_event,
  output logic [7:0]                    periodic_event
);

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic [7:0] mode_mask(
    input rtc_irq_pkg::counter_mode_t mode
  );
    logic [7:0] m;
    m = rtc_irq_pkg::MASK_RESERVED;
    unique case (mode)
      rtc_irq_pkg::COUNTER32_MODE: m = rtc_irq_pkg::MASK_COUNTER32;
      rtc_irq_pkg::COUNTER16_MODE: m = rtc_irq_pkg::MASK_COUNTER16;
      rtc_irq_pkg::CALENDAR_MODE:  m = rtc_irq_pkg::MASK_CALENDAR;
      rtc_irq_pkg::RESERVED_MODE:  m = rtc_irq_pkg::MASK_RESERVED;
    endcase
    return m;
  endfunction : mode_mask

  function automatic logic hit(
    input rtc_irq_pkg::bus_req_t req,
    input logic [7:0]            ofs
  );
    return req.wr && (req.addr == ofs);
  endfunction : hit

  // ************************************************************
  // state
  // ************************************************************
  rtc_irq_pkg::counter_mode_t mode_q;
  logic [8:0]                 evctrl_q;
  logic [7:0]                 enable_q;
  logic [7:0]                 enable_d;
  logic [7:0]                 flags_q;
  logic [7:0]                 flags_d;
  logic [7:0]                 flag_set;
  logic [7:0]                 active_mask;
  logic [7:0]                 pending;
  logic [7:0]                 rd_data_d;
  logic                       wr_ctrl;
  logic                       wr_evlo;
  logic                       wr_evhi;
  logic                       wr_clr;
  logic                       wr_set;
  logic                       wr_flags;

  assign active_mask = mode_mask(mode_q);

  // ************************************************************
  // write decode
  // ************************************************************
  always_comb begin
    wr_ctrl  = hit(bus_req, rtc_irq_pkg::CTRL_OFS);
    wr_evlo  = hit(bus_req, rtc_irq_pkg::EVCTRL_LO_OFS);
    wr_evhi  = hit(bus_req, rtc_irq_pkg::EVCTRL_HI_OFS);
    wr_clr   = hit(bus_req, rtc_irq_pkg::IRQ_CLR_OFS);
    wr_set   = hit(bus_req, rtc_irq_pkg::IRQ_SET_OFS);
    wr_flags = hit(bus_req, rtc_irq_pkg::IRQ_FLAGS_OFS);
  end

  // ************************************************************
  // counter mode
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mode_q <= rtc_irq_pkg::counter_mode_t'(rtc_irq_pkg::MODE_RST);
    end else if (clk_en && wr_ctrl && !write_protect) begin
      mode_q <= rtc_irq_pkg::counter_mode_t'(
                  bus_req.wdata[rtc_irq_pkg::MODE_LSB +: 2]);
    end
  end

  // ************************************************************
  // event output enables
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      evctrl_q <= rtc_irq_pkg::EVCTRL_RST;
    end else if (clk_en && !write_protect) begin
      if (wr_evlo) begin
        evctrl_q[7:0] <= bus_req.wdata;
      end
      if (wr_evhi) begin
        evctrl_q[rtc_irq_pkg::ALARM_EO_BIT] <= bus_req.wdata[0];
      end
    end
  end

  // ************************************************************
  // interrupt enables
  // ************************************************************
  always_comb begin
    enable_d = enable_q;
    if (!write_protect) begin                          // [R13]
      if (wr_clr) begin
        // ones clear, zeros keep; mask covers the mode's live bits
        enable_d = enable_q & ~(bus_req.wdata & active_mask); // [R3]
      end
      if (wr_set) begin
        enable_d = enable_q | (bus_req.wdata & active_mask);  // [R11]
      end
    end
  end

  // bit 7 and 6 in every mode, bit 0 and 1 per mode   [R4] [R5]
  // counter32 bit 0 is compare zero                   [R6]
  // counter16 bits 1:0 are the two compare channels   [R7]
  // calendar bit 0 is alarm zero                      [R10]
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      enable_q <= rtc_irq_pkg::ENABLE_RST;             // [R13]
    end else if (clk_en) begin
      enable_q <= enable_d;                            // [R14]
    end
  end

  // ************************************************************
  // interrupt flags
  // ************************************************************
  always_comb begin
    flag_set = '0;
    flag_set[rtc_irq_pkg::OVF_BIT]  = src_events.overflow;
    flag_set[rtc_irq_pkg::SYNC_BIT] = src_events.sync_ready;
    unique case (mode_q)
      rtc_irq_pkg::COUNTER32_MODE: begin
        flag_set[rtc_irq_pkg::CHAN0_BIT] = src_events.compare_chan[0];
      end
      rtc_irq_pkg::COUNTER16_MODE: begin
        flag_set[rtc_irq_pkg::CHAN0_BIT] = src_events.compare_chan[0];
        flag_set[rtc_irq_pkg::CHAN1_BIT] = src_events.compare_chan[1];
      end
      rtc_irq_pkg::CALENDAR_MODE: begin
        flag_set[rtc_irq_pkg::CHAN0_BIT] = src_events.alarm_zero;
      end
      rtc_irq_pkg::RESERVED_MODE: begin
        flag_set[rtc_irq_pkg::CHAN0_BIT] = 1'h0;
      end
    endcase
  end

  // a set arriving with its clear wins
  genvar fb;
  generate
    for (fb = 0; fb < 8; fb++) begin : g_flag
      always_comb begin
        flags_d[fb] = flags_q[fb];
        if (wr_flags && bus_req.wdata[fb]) begin
          flags_d[fb] = 1'h0;                          // [R12]
        end
        if (flag_set[fb]) begin
          flags_d[fb] = 1'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flags_q <= rtc_irq_pkg::FLAGS_RST;
    end else if (clk_en) begin
      flags_q <= flags_d & active_mask;
    end
  end

  // ************************************************************
  // interrupt request
  // ************************************************************
  // a source pends only while its enable, its flag and the mode agree
  genvar qb;
  generate
    for (qb = 0; qb < 8; qb++) begin : g_pending
      always_comb begin
        pending[qb] = enable_q[qb] && flags_q[qb] && active_mask[qb]; // [R8]
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_req <= 1'h0;
    end else if (clk_en) begin
      irq_req <= |pending;                             // [R8]
    end
  end

  // ************************************************************
  // event outputs
  // ************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      alarm_zero_event <= 1'h0;
    end else if (clk_en) begin
      alarm_zero_event <= src_events.alarm_zero
                          && evctrl_q[rtc_irq_pkg::ALARM_EO_BIT]; // [R1]
    end
  end

  genvar pb;
  generate
    for (pb = 0; pb < 8; pb++) begin : g_periodic
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          periodic_event[pb] <= 1'h0;
        end else if (clk_en) begin
          periodic_event[pb] <= src_events.periodic[pb]
                                && evctrl_q[pb];       // [R2]
        end
      end
    end
  endgenerate

  // ************************************************************
  // read path
  // ************************************************************
  always_comb begin
    rd_data_d = rtc_irq_pkg::RDATA_RST;
    unique case (bus_req.addr)
      rtc_irq_pkg::CTRL_OFS: begin
        rd_data_d[rtc_irq_pkg::MODE_LSB +: 2] = mode_q;
      end
      rtc_irq_pkg::EVCTRL_LO_OFS: begin
        rd_data_d = evctrl_q[7:0];
      end
      rtc_irq_pkg::EVCTRL_HI_OFS: begin
        rd_data_d[0] = evctrl_q[rtc_irq_pkg::ALARM_EO_BIT];
      end
      rtc_irq_pkg::IRQ_CLR_OFS,
      rtc_irq_pkg::IRQ_SET_OFS: begin
        rd_data_d = enable_q & active_mask;            // [R9] [R14]
      end
      rtc_irq_pkg::IRQ_FLAGS_OFS: begin
        rd_data_d = flags_q & active_mask;
      end
      default: begin
        rd_data_d = rtc_irq_pkg::RDATA_RST;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rd_data <= rtc_irq_pkg::RDATA_RST;
    end else if (clk_en) begin
      if (bus_req.rd) begin
        rd_data <= rd_data_d;
      end else begin
        rd_data <= rtc_irq_pkg::RDATA_RST;
      end
    end
  end

endmodule : rtc_irq_event_enable_clear

// >>> rtc_irq_event_enable_clear_sva.sv
// concurrent checks of the interrupt-enable and event-output block
// assumes it is bound onto the block and sees only its ports
module rtc_irq_event_enable_clear_sva (
  input wire logic                     clock,
  input wire logic                     rst_n,
  input wire logic                     clk_en,
  input wire logic                     write_protect,
  input wire rtc_irq_pkg::bus_req_t    bus_req,
  input wire rtc_irq_pkg::src_events_t src_events,
  input wire logic [7:0]               rd_data,
  input wire logic                     irq_req,
  input wire logic                     alarm_zero_event,
  input wire logic [7:0]               periodic_event
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  property p_rd_idle;
    clk_en && !bus_req.rd |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_unmapped;
    clk_en && bus_req.rd && bus_req.addr > 8'h08 |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_unused;
    clk_en && bus_req.rd && bus_req.addr == 8'h06 |=> rd_data[5:2] == 4'h0;
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused enable bits not zero");
  property p_alarm;
    alarm_zero_event && $past(clk_en) |-> $past(src_events.alarm_zero);
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm event without alarm");
  property p_periodic;
    $past(clk_en) |-> (periodic_event & ~$past(src_events.periodic)) == 8'h00;
  endproperty
  a_periodic: assert property (p_periodic)
    else $error("periodic event without interval");
  sequence s_clear_all;
    clk_en && !write_protect && bus_req.wr && bus_req.addr == 8'h06
      && bus_req.wdata == 8'hFF ##1 clk_en;
  endsequence
  property p_clear_all;
    s_clear_all |=> !irq_req;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("request stays after clearing all enables");
  property p_irq_fall;
    $fell(irq_req) && $past(clk_en) && $past(clk_en, 2)
      |-> $past(bus_req.wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("request dropped without a write");
  property p_irq_rise;
    $rose(irq_req) && $past(clk_en) && $past(clk_en, 2)
      |-> $past(bus_req.wr, 2) || $past(src_events, 2) != '0;
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("request raised without cause");
  c_read: cover property (bus_req.rd ##1 rd_data != 8'h00);
  c_alarm: cover property (alarm_zero_event);
  c_irq: cover property ($rose(irq_req));
endmodule : rtc_irq_event_enable_clear_sva

bind rtc_irq_event_enable_clear rtc_irq_event_enable_clear_sva i_sva (
  .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
  .write_protect(write_protect), .bus_req(bus_req),
  .src_events(src_events), .rd_data(rd_data), .irq_req(irq_req),
  .alarm_zero_event(alarm_zero_event), .periodic_event(periodic_event));

// >>> rtc_irq_event_enable_clear_test.sv
// self-checking bench of the interrupt-enable and event-output block
// assumes the package and the block are compiled before it
module rtc_irq_event_enable_clear_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals and tasks
  // ****************************************
  localparam logic [7:0] CLR = 8'h06;
  localparam logic [7:0] SET = 8'h07;
  localparam logic [7:0] FLG = 8'h08;
  logic                     clock;
  logic                     rst_n;
  logic                     clk_en;
  logic                     write_protect;
  rtc_irq_pkg::bus_req_t    bus_req;
  rtc_irq_pkg::src_events_t src_events;
  logic [7:0]               rd_data;
  logic                     irq_req;
  logic                     alarm_zero_event;
  logic [7:0]               periodic_event;
  int                       mismatches;
  int                       tests_run;
  logic [7:0]               modes [3] = '{8'h01, 8'h00, 8'h02};
  logic [7:0]               masks [3] = '{8'hC3, 8'hC1, 8'hC1};

  rtc_irq_event_enable_clear i_dut (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .write_protect(write_protect), .bus_req(bus_req),
    .src_events(src_events), .rd_data(rd_data), .irq_req(irq_req),
    .alarm_zero_event(alarm_zero_event), .periodic_event(periodic_event));

  task automatic final_report();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic check8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check8

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clock);
    bus_req.wr <= 1'h0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e,
                        input string n);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clock);
    bus_req.rd <= 1'h0;
    #1;
    check8(n, e, rd_data);
  endtask : reg_rd

  task automatic pulse(input rtc_irq_pkg::src_events_t v);
    @(posedge clock);
    src_events <= v;
    @(posedge clock);
    src_events <= '0;
    #1;
  endtask : pulse

  task automatic irq_chk(input logic e);
    @(posedge clock);
    #1;
    check8("irq_req", {7'h00, e}, {7'h00, irq_req});
  endtask : irq_chk

  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  initial begin
    #20000;
    mismatches++;
    final_report();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    rst_n = 1'h0;
    clk_en = 1'h1;
    write_protect = 1'h0;
    bus_req = '0;
    src_events = '0;
    mismatches = 0;
    tests_run = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    reg_rd(CLR, 8'h00, "enable_reset");
    reg_rd(FLG, 8'h00, "flags_reset");
    for (int i = 0; i < 3; i++) begin
      reg_wr(8'h00, modes[i]);
      reg_wr(SET, 8'hFF);
      reg_rd(CLR, masks[i], "set_all");
      reg_wr(CLR, 8'h00);
      reg_rd(CLR, masks[i], "clear_zero");
      reg_wr(CLR, 8'h02);
      reg_rd(CLR, masks[i] & 8'hC1, "clear_bit1");
      reg_wr(CLR, 8'h01);
      reg_rd(CLR, 8'hC0, "clear_bit0");
      reg_wr(CLR, 8'h80);
      reg_rd(CLR, 8'h40, "clear_bit7");
      reg_wr(CLR, 8'h40);
      reg_rd(CLR, 8'h00, "clear_bit6");
    end
    reg_wr(SET, 8'hFF);
    @(posedge clock);
    write_protect <= 1'h1;
    reg_wr(CLR, 8'hFF);
    reg_rd(CLR, 8'hC1, "protected");
    @(posedge clock);
    write_protect <= 1'h0;
    reg_wr(CLR, 8'h01);
    pulse('{overflow: 1'h1, default: '0});
    irq_chk(1'h1);
    reg_rd(FLG, 8'h80, "flag_set");
    reg_wr(CLR, 8'hFF);
    irq_chk(1'h0);
    reg_wr(SET, 8'h80);
    irq_chk(1'h1);
    reg_wr(FLG, 8'h7F);
    reg_rd(FLG, 8'h80, "flag_zero_write");
    reg_wr(FLG, 8'h80);
    irq_chk(1'h0);
    reg_wr(8'h04, 8'h5A);
    reg_wr(8'h05, 8'h01);
    pulse('{alarm_zero: 1'h1, periodic: 8'hFF, default: '0});
    check8("periodic_event", 8'h5A, periodic_event);
    check8("alarm_on", 8'h01, {7'h00, alarm_zero_event});
    reg_wr(8'h05, 8'h00);
    pulse('{alarm_zero: 1'h1, default: '0});
    check8("alarm_off", 8'h00, {7'h00, alarm_zero_event});
    reg_rd(FLG, 8'h01, "alarm_flag");
    reg_wr(SET, 8'h01);
    irq_chk(1'h1);
    reg_wr(CLR, 8'h01);
    irq_chk(1'h0);
    pulse('{sync_ready: 1'h1, default: '0});
    irq_chk(1'h0);
    reg_wr(SET, 8'h40);
    irq_chk(1'h1);
    reg_wr(CLR, 8'h40);
    irq_chk(1'h0);
    reg_wr(FLG, 8'hFF);
    reg_wr(8'h00, 8'h01);
    pulse('{compare_chan: 2'h2, default: '0});
    reg_rd(FLG, 8'h02, "chan1_flag");
    reg_wr(SET, 8'h02);
    irq_chk(1'h1);
    reg_wr(CLR, 8'h02);
    irq_chk(1'h0);
    fork
      pulse('{compare_chan: 2'h1, default: '0});
      reg_wr(FLG, 8'h01);
    join
    reg_rd(FLG, 8'h03, "set_wins");
    @(posedge clock);
    clk_en <= 1'h0;
    reg_wr(SET, 8'hFF);
    clk_en <= 1'h1;
    reg_rd(CLR, 8'h80, "frozen");
    reg_wr(8'h00, 8'h03);
    reg_wr(SET, 8'hFF);
    reg_rd(CLR, 8'hC0, "reserved_mode");
    reg_rd(8'h3F, 8'h00, "unmapped");
    final_report();
  end
endmodule : rtc_irq_event_enable_clear_test

// >>> rtc_irq_pkg.sv
// holds offsets, field layouts, reset values and carriers of the
// real-time counter interrupt-enable and event-output block.
// assumes an 8-bit register port and a single 125 MHz clock.
package rtc_irq_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] EVCTRL_LO_OFS  = 8'h04;
  localparam logic [7:0] EVCTRL_HI_OFS  = 8'h05;
  localparam logic [7:0] IRQ_CLR_OFS    = 8'h06;
  localparam logic [7:0] IRQ_SET_OFS    = 8'h07;
  localparam logic [7:0] IRQ_FLAGS_OFS  = 8'h08;

  // ************************************************************
  // field positions and masks
  // ************************************************************
  localparam int         OVF_BIT        = 7;
  localparam int         SYNC_BIT       = 6;
  localparam int         CHAN1_BIT      = 1;
  localparam int         CHAN0_BIT      = 0;
  localparam int         ALARM_EO_BIT   = 8;
  localparam int         MODE_LSB       = 0;
  localparam logic [7:0] MASK_COUNTER32 = 8'hC1;
  localparam logic [7:0] MASK_COUNTER16 = 8'hC3;
  localparam logic [7:0] MASK_CALENDAR  = 8'hC1;
  localparam logic [7:0] MASK_RESERVED  = 8'hC0;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] ENABLE_RST     = 8'h00;
  localparam logic [7:0] FLAGS_RST      = 8'h00;
  localparam logic [8:0] EVCTRL_RST     = 9'h000;
  localparam logic [1:0] MODE_RST       = 2'h0;
  localparam logic [7:0] RDATA_RST      = 8'h00;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    COUNTER32_MODE = 2'b00,
    COUNTER16_MODE = 2'b01,
    CALENDAR_MODE  = 2'b10,
    RESERVED_MODE  = 2'b11
  } counter_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic       overflow;
    logic       sync_ready;
    logic [1:0] compare_chan;
    logic       alarm_zero;
    logic [7:0] periodic;
  } src_events_t;

endpackage : rtc_irq_pkg
